// ### rtl/board_glue_consts.vh
`ifndef BOARD_GLUE_CONSTS_VH
`define BOARD_GLUE_CONSTS_VH

// ****************************************
// address windows, first and last byte
// ****************************************
`define WIN_BRAM_LO   32'h00000000
`define WIN_BRAM_HI   32'h00001FFF
`define WIN_SDRAM_LO  32'h80000000
`define WIN_SDRAM_HI  32'h80FFFFFF
`define WIN_FLASH_LO  32'hFF000000
`define WIN_FLASH_HI  32'hFF7FFFFF
`define WIN_LAN_LO    32'hFFE00000
`define WIN_LAN_HI    32'hFFEFFFFF
`define WIN_TIMER_LO  32'hFFFF1000
`define WIN_TIMER_HI  32'hFFFF10FF
`define WIN_UART_LO   32'hFFFF2000
`define WIN_UART_HI   32'hFFFF20FF
`define WIN_INTC_LO   32'hFFFF3000
`define WIN_INTC_HI   32'hFFFF30FF
`define WIN_BOOT_LO   32'hFFFFA000
`define WIN_BOOT_HI   32'hFFFFA1FF
`define WIN_LED_LO    32'hFFFFA200
`define WIN_LED_HI    32'hFFFFA3FF

// ****************************************
// local port registers
// ****************************************
`define BOOT_PORT_ADDR  32'hFFFFA000
`define LED_PORT_ADDR   32'hFFFFA200
`define SOFT_RESET_KEY  32'h00000001
`define LED_RESET       1'h0
`define BOOT_BIT        0
`define PROG_BIT        1
`define LED_BIT         0

// ****************************************
// serial flash layout
// ****************************************
`define CFG_REGION_BYTES 32'h00100000

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS   100
`define RELOAD_NS       1000
`define DEVRST_NS       10000
`define RELOAD_CYC      ((`RELOAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_CAPTURE   2'h2
`define STRAP_DONE      2'h3
`define DEVRST_CYC      ((`DEVRST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### rtl/board_address_decode_and_reset.v
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "board_glue_consts.vh"

// How it works
// - 0x00000000..0x00001FFF selects block RAM.
// - 0x80000000..0x80FFFFFF selects the SDRAM controller.
// - 0xFF000000..0xFF7FFFFF selects the serial flash controller.
// - 0xFFE00000..0xFFEFFFFF selects the LAN memory controller.
// - 0xFFFF1000..0xFFFF10FF selects the timer.
// - 0xFFFF2000..0xFFFF20FF selects the UART.
// - 0xFFFF3000..0xFFFF30FF selects the interrupt controller.
// - 0xFFFFA000..0xFFFFA1FF is the boot-mode and soft-reset port.
// - 0xFFFFA200..0xFFFFA3FF is the LED port.
// - unassigned addresses select no target at all.
// - writing 1 to the reset port reloads configuration (not when stalled), then resets devices.
// - configuration image lives in the first 1MB of flash.
// - boot jumper open means auto boot, shorted means loader; readable.
// - program jumper shorted at power-on stalls configuration.
// - user LED pin is driven low to light it.
module board_address_decode_and_reset
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout_r,
	output reg  [31:0] hrdata_r,
	output reg         hresp_r,
	output reg  [6:0]  tgt_sel_r,
	output reg  [31:0] tgt_addr_r,
	output reg         tgt_write_r,
	output reg  [31:0] tgt_wdata_r,
	output reg         tgt_cfg_region_r,
	input  wire        ext_ready,
	input  wire [31:0] ext_rdata,
	input  wire        boot_mode_jumper,
	input  wire        flash_program_jumper,
	output reg         user_led_n_r,
	output reg         cfg_reload_n_r,
	output reg         dev_reset_n_r,
	output reg         cfg_stall_r
);

	// ****************************************
	// window table, index 0..6 external, 7..8 local
	// ****************************************
	localparam NWIN = 9;
	localparam [NWIN*32-1:0] WIN_LO = {
		`WIN_LED_LO, `WIN_BOOT_LO, `WIN_INTC_LO, `WIN_UART_LO, `WIN_TIMER_LO,
		`WIN_LAN_LO, `WIN_FLASH_LO, `WIN_SDRAM_LO, `WIN_BRAM_LO};
	localparam [NWIN*32-1:0] WIN_HI = {
		`WIN_LED_HI, `WIN_BOOT_HI, `WIN_INTC_HI, `WIN_UART_HI, `WIN_TIMER_HI,
		`WIN_LAN_HI, `WIN_FLASH_HI, `WIN_SDRAM_HI, `WIN_BRAM_HI};
	localparam W_FLASH = 2;
	localparam W_BOOT  = 7;
	localparam W_LED   = 8;

	// bus state, one-hot
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_WDAT = 3'h2;
	localparam [2:0] ST_EXT  = 3'h4;

	// soft reset sequence, one-hot
	localparam [2:0] RS_IDLE   = 3'h1;
	localparam [2:0] RS_RELOAD = 3'h2;
	localparam [2:0] RS_DEVRST = 3'h4;

	// cycle counts cut to the counter width on purpose
	localparam integer RELOAD_I   = `RELOAD_CYC;
	localparam integer DEVRST_I   = `DEVRST_CYC;
	localparam [7:0]   RELOAD_CNT = RELOAD_I[7:0];
	localparam [7:0]   DEVRST_CNT = DEVRST_I[7:0];

	wire [NWIN-1:0] hit;
	wire            accept;
	wire            ext_hit;

	reg  [2:0]  st_r;
	reg  [2:0]  st_nxt;
	reg  [NWIN-1:0] win_r;
	reg  [31:0] addr_r;
	reg         wr_r;
	reg         lwr_pend_r;
	reg         led_r;
	reg  [2:0]  rs_r;
	reg  [7:0]  rs_cnt_r;
	reg         boot_s1_r;
	reg         boot_s2_r;
	reg         prog_s1_r;
	reg         prog_s2_r;
	reg  [1:0]  strap_cnt_r;
	reg  [31:0] local_rd;

	// ****************************************
	// address decode
	// ****************************************
	// plain range compare per window; the reserved range has no entry,
	// so block RAM alone claims 0x1000..0x1FFF
	genvar gi;
	generate
		for (gi = 0; gi < NWIN; gi = gi + 1)
		begin : g_win
			assign hit[gi] = (haddr >= WIN_LO[gi*32 +: 32]) &&
			                 (haddr <= WIN_HI[gi*32 +: 32]);
		end
	endgenerate

	assign accept  = hsel && htrans[1] && hready;
	// no hit anywhere means no target: free space answers locally
	assign ext_hit = |hit[6:0];

	// ****************************************
	// pin synchronisers and power-on straps
	// ****************************************
	// jumpers are off-domain pins, two flops before use
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			boot_s1_r <= 1'h0;
			boot_s2_r <= 1'h0;
			prog_s1_r <= 1'h0;
			prog_s2_r <= 1'h0;
		end
		else
		begin
			boot_s1_r <= boot_mode_jumper;
			boot_s2_r <= boot_s1_r;
			prog_s1_r <= flash_program_jumper;
			prog_s2_r <= prog_s1_r;
		end
	end

	// program jumper caught once, shorted reads low; taken on the third
	// edge after release, as earlier the flops still hold their reset level
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			strap_cnt_r <= 2'h0;
			cfg_stall_r <= 1'h0;
		end
		else if (strap_cnt_r != `STRAP_DONE)
		begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
			if (strap_cnt_r == `STRAP_CAPTURE)
				cfg_stall_r <= ~prog_s2_r;
		end
	end

	// ****************************************
	// local read data
	// ****************************************
	// boot level is the jumper's own level: 1 open (auto), 0 shorted (loader)
	always @*
	begin
		local_rd = 32'h00000000;
		if (hit[W_BOOT] && haddr == `BOOT_PORT_ADDR)
		begin
			local_rd[`BOOT_BIT] = boot_s2_r;
			local_rd[`PROG_BIT] = cfg_stall_r;
		end
		else if (hit[W_LED] && haddr == `LED_PORT_ADDR)
			local_rd[`LED_BIT] = led_r;
	end

	// ****************************************
	// bus state machine
	// ****************************************
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE:
				if (accept && ext_hit)
					st_nxt = ST_WDAT;
			ST_WDAT:
				st_nxt = ST_EXT;
			ST_EXT:
				if (ext_ready)
					st_nxt = ST_IDLE;
			default:
				st_nxt = ST_IDLE;
		endcase
	end

	// external accesses stall the bus until the target answers;
	// local and free ones take no wait state
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_r             <= ST_IDLE;
			hreadyout_r      <= 1'h1;
			hrdata_r         <= 32'h00000000;
			hresp_r          <= 1'h0;
			win_r            <= {NWIN{1'b0}};
			addr_r           <= 32'h00000000;
			wr_r             <= 1'h0;
			lwr_pend_r       <= 1'h0;
			tgt_sel_r        <= 7'h00;
			tgt_addr_r       <= 32'h00000000;
			tgt_write_r      <= 1'h0;
			tgt_wdata_r      <= 32'h00000000;
			tgt_cfg_region_r <= 1'h0;
		end
		else
		begin
			st_r       <= st_nxt;
			hresp_r    <= 1'h0;
			lwr_pend_r <= 1'h0;
			case (st_r)
				ST_IDLE:
					if (accept)
					begin
						win_r  <= hit;
						addr_r <= haddr;
						wr_r   <= hwrite;
						if (ext_hit)
							hreadyout_r <= 1'h0;
						else
						begin
							// local port or free space: local_rd on reads, writes left to the data phase
							hrdata_r   <= hwrite ? 32'h00000000 : local_rd;
							lwr_pend_r <= hwrite;
						end
					end
				ST_WDAT:
				begin
					tgt_sel_r   <= win_r[6:0];
					tgt_addr_r  <= addr_r;
					tgt_write_r <= wr_r;
					tgt_wdata_r <= hwdata;
					// offsets below 1MB in flash touch the configuration image
					tgt_cfg_region_r <= win_r[W_FLASH] &&
						(addr_r - `WIN_FLASH_LO) < `CFG_REGION_BYTES;
				end
				ST_EXT:
					if (ext_ready)
					begin
						hrdata_r         <= wr_r ? 32'h00000000 : ext_rdata;
						hreadyout_r      <= 1'h1;
						tgt_sel_r        <= 7'h00;
						tgt_write_r      <= 1'h0;
						tgt_cfg_region_r <= 1'h0;
					end
				default:
					hreadyout_r <= 1'h1;
			endcase
		end
	end

	// ****************************************
	// LED port
	// ****************************************
	// write applied in the data phase, when hwdata stands
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			led_r        <= `LED_RESET;
			user_led_n_r <= 1'h1;
		end
		else
		begin
			if (lwr_pend_r && win_r[W_LED] && addr_r == `LED_PORT_ADDR)
				led_r <= hwdata[`LED_BIT];
			user_led_n_r <= ~led_r;
		end
	end

	// ****************************************
	// software reset sequence
	// ****************************************
	// reload pulse first, device reset after; the reload itself wipes
	// this logic in a real part, so the device reset leg only shows
	// when the fabric survives (e.g. reload held off by the strap)
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rs_r           <= RS_IDLE;
			rs_cnt_r       <= 8'h00;
			cfg_reload_n_r <= 1'h1;
			dev_reset_n_r  <= 1'h1;
		end
		else
		begin
			case (rs_r)
				RS_IDLE:
					// software is expected to be quiet on SDRAM and devices here
					if (lwr_pend_r && win_r[W_BOOT] && addr_r == `BOOT_PORT_ADDR &&
					    hwdata == `SOFT_RESET_KEY)
					begin
						rs_r           <= RS_RELOAD;
						rs_cnt_r       <= RELOAD_CNT - 8'h01;
						// stalled configuration: no reload is driven
						cfg_reload_n_r <= cfg_stall_r;
					end
				RS_RELOAD:
					if (rs_cnt_r == 8'h00)
					begin
						rs_r           <= RS_DEVRST;
						rs_cnt_r       <= DEVRST_CNT - 8'h01;
						cfg_reload_n_r <= 1'h1;
						dev_reset_n_r  <= 1'h0;
					end
					else
						rs_cnt_r <= rs_cnt_r - 8'h01;
				RS_DEVRST:
					if (rs_cnt_r == 8'h00)
					begin
						rs_r          <= RS_IDLE;
						dev_reset_n_r <= 1'h1;
					end
					else
						rs_cnt_r <= rs_cnt_r - 8'h01;
				default:
				begin
					rs_r           <= RS_IDLE;
					cfg_reload_n_r <= 1'h1;
					dev_reset_n_r  <= 1'h1;
				end
			endcase
		end
	end

endmodule

// ### tb/board_glue_props.sv
`timescale 1ns/1ns
module board_glue_props
(
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hready,
	input wire        hreadyout_r,
	input wire        hresp_r,
	input wire [6:0]  tgt_sel_r,
	input wire [31:0] tgt_addr_r,
	input wire        tgt_cfg_region_r,
	input wire        ext_ready,
	input wire        cfg_reload_n_r,
	input wire        dev_reset_n_r,
	input wire        cfg_stall_r
);
	// ****************************************
	// accept strobe and defaults
	// ****************************************
	wire acc = hsel && htrans[1] && hready;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// routing, one property each for free space, block RAM, SDRAM, LAN and timer
	property p_okay; hresp_r == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("bad response");
	property p_free;
		acc && haddr >= 32'h81000000 && haddr <= 32'hFEFFFFFF |=>
			hreadyout_r && tgt_sel_r == 7'h00 ##1 tgt_sel_r == 7'h00;
	endproperty
	a_free: assert property (p_free) else $error("free window misrouted");
	property p_bram; acc && haddr <= 32'h1FFF |=> !hreadyout_r ##1 tgt_sel_r == 7'h01; endproperty
	a_bram: assert property (p_bram) else $error("bram misrouted");
	property p_sdram; acc && haddr[31:24] == 8'h80 |=> !hreadyout_r ##1 tgt_sel_r == 7'h02;
	endproperty
	a_sdram: assert property (p_sdram) else $error("sdram misrouted");
	property p_lan; acc && haddr[31:20] == 12'hFFE |=> ##1 tgt_sel_r == 7'h08; endproperty
	a_lan: assert property (p_lan) else $error("lan misrouted");
	property p_timer; acc && haddr[31:8] == 24'hFFFF10 |=> ##1 tgt_sel_r == 7'h10; endproperty
	a_timer: assert property (p_timer) else $error("timer misrouted");
	// flash flag must track the first megabyte exactly
	property p_region; tgt_sel_r[2] |-> tgt_cfg_region_r == (tgt_addr_r < 32'hFF100000);
	endproperty
	a_region: assert property (p_region) else $error("config region flag wrong");
	// reload first, device reset only after it
	property p_reload;
		$fell(cfg_reload_n_r) |-> !cfg_reload_n_r[*8] ##1 !cfg_reload_n_r[*2]
			##1 (cfg_reload_n_r && !dev_reset_n_r);
	endproperty
	a_reload: assert property (p_reload) else $error("reload sequence wrong");
	property p_devrst; $fell(dev_reset_n_r) |-> ##100 (dev_reset_n_r && !$past(dev_reset_n_r));
	endproperty
	a_devrst: assert property (p_devrst) else $error("device reset length wrong");
	property p_stall; cfg_stall_r |-> cfg_reload_n_r; endproperty
	a_stall: assert property (p_stall) else $error("reload while stalled");
endmodule
bind board_address_decode_and_reset board_glue_props chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hready(hready), .hreadyout_r(hreadyout_r),
	.hresp_r(hresp_r), .tgt_sel_r(tgt_sel_r), .tgt_addr_r(tgt_addr_r),
	.tgt_cfg_region_r(tgt_cfg_region_r), .ext_ready(ext_ready),
	.cfg_reload_n_r(cfg_reload_n_r), .dev_reset_n_r(dev_reset_n_r), .cfg_stall_r(cfg_stall_r));

// ### tb/tgt_responder.sv
`timescale 1ns/1ns
module tgt_responder
(
	input wire        hclk,
	input wire [6:0]  sel,
	input wire [31:0] addr,
	input wire [3:0]  dly,
	output reg        ready,
	output reg [31:0] rdata
);
	integer n;
	initial
	begin
		ready = 1'b0;
		rdata = 32'h0;
		n = 0;
	end
	// idle data toggles so a stale capture never matches
	always @(posedge hclk)
	begin
		ready <= 1'b0;
		rdata <= ~rdata;
		if (sel != 7'h00 && !ready)
		begin
			if (n >= dly)
			begin
				ready <= 1'b1;
				rdata <= addr ^ 32'h5A5A0000;
				n <= 0;
			end
			else
				n <= n + 1;
		end
	end
endmodule

// ### tb/board_address_decode_and_reset_tb.sv
`timescale 1ns/1ns
`include "board_glue_consts.vh"
module board_address_decode_and_reset_tb;
	// ****************************************
	// bench signals
	// ****************************************
	reg         hclk, hresetn, hsel, hwrite, bj, pj, w;
	reg  [1:0]  htrans;
	reg  [31:0] haddr, hwdata, rd, a, d, e;
	reg  [6:0]  cap;
	reg  [31:0] ca, cd;
	reg         cw, cr;
	reg  [3:0]  dly;
	wire        hrdy, hresp, twr, cfgr, led_n, rel_n, dev_n, stall, xrdy;
	wire [31:0] hrdata, taddr, twdata, xrdata;
	wire [6:0]  tsel;
	integer     miscompares, cmp_count, seed, i;
	logic [31:0] edges [17] = '{32'h1FFF, 32'h2000, 32'h80FFFFFF, 32'h81000000, 32'hFF7FFFFF,
		32'hFF0FFFFF, 32'hFF100000,
		32'hFF800000, 32'hFFEFFFFF, 32'hFFF00000, 32'hFFFF10FF, 32'hFFFF1100, 32'hFFFF20FF,
		32'hFFFF30FF, 32'hFFFF3100, 32'hFFFFA004, 32'hFFFFA400};
	board_address_decode_and_reset DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hrdy), .hreadyout_r(hrdy), .hrdata_r(hrdata), .hresp_r(hresp),
		.tgt_sel_r(tsel), .tgt_addr_r(taddr), .tgt_write_r(twr), .tgt_wdata_r(twdata),
		.tgt_cfg_region_r(cfgr), .ext_ready(xrdy), .ext_rdata(xrdata),
		.boot_mode_jumper(bj), .flash_program_jumper(pj), .user_led_n_r(led_n),
		.cfg_reload_n_r(rel_n), .dev_reset_n_r(dev_n), .cfg_stall_r(stall));
	tgt_responder far (.hclk(hclk), .sel(tsel), .addr(taddr), .dly(dly), .ready(xrdy),
		.rdata(xrdata));
	// reference decode, written from the address map
	function [6:0] esel(input [31:0] x);
		esel = 7'h00;
		if (x <= `WIN_BRAM_HI) esel = 7'h01;
		if (x >= `WIN_SDRAM_LO && x <= `WIN_SDRAM_HI) esel = 7'h02;
		if (x >= `WIN_FLASH_LO && x <= `WIN_FLASH_HI) esel = 7'h04;
		if (x >= `WIN_LAN_LO && x <= `WIN_LAN_HI) esel = 7'h08;
		if (x >= `WIN_TIMER_LO && x <= `WIN_TIMER_HI) esel = 7'h10;
		if (x >= `WIN_UART_LO && x <= `WIN_UART_HI) esel = 7'h20;
		if (x >= `WIN_INTC_LO && x <= `WIN_INTC_HI) esel = 7'h40;
	endfunction
	// one single transfer; ready doubles as the bus hready
	task xfer(input [31:0] ad, input wr, input [31:0] wd);
		hsel <= 1'b1; haddr <= ad; htrans <= 2'b10; hwrite <= wr;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd; cap = 7'h00;
		@(posedge hclk);
		while (hrdy !== 1'b1)
		begin
			if (tsel != 7'h00)
			begin
				cap = tsel;
				ca = taddr;
				cw = twr;
				cd = twdata;
				cr = cfgr;
			end
			@(posedge hclk);
		end
		rd = hrdata;
	endtask
	task chk(input [31:0] g, input [31:0] x);
		cmp_count = cmp_count + 1;
		if (g !== x)
		begin
			miscompares = miscompares + 1;
			$display("[ERR] t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// full decode check of one address against the model
	task probe(input [31:0] ad);
		w = $random(seed);
		d = $random(seed);
		dly <= 4'($random(seed) & 7);
		xfer(ad, w, d);
		e = (esel(ad) != 7'h00) ? ad ^ 32'h5A5A0000 : 32'h0;
		chk({25'h0, cap}, {25'h0, esel(ad)});
		if (!w) chk(rd, e);
		// target side must carry the word as the master put it
		if (esel(ad) != 7'h00)
		begin
			chk(ca, ad);
			chk({31'h0, cw}, {31'h0, w});
			if (w) chk(cd, d);
			chk({31'h0, cr}, {31'h0, (esel(ad) == 7'h04) &&
				((ad - `WIN_FLASH_LO) < `CFG_REGION_BYTES)});
		end
	endtask
	task results;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	// watchdog, far beyond the thousand or so cycles the run needs
	initial
	begin
		#3000000;
		miscompares = miscompares + 1;
		results;
	end
	initial
	begin
		miscompares = 0; cmp_count = 0; seed = 32'hc356;
		hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00; haddr = 32'h0;
		hwdata = 32'h0; bj = 1'b1; pj = 1'b1; dly = 4'h0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		// window edges then random addresses in each external window, plus fully random ones
		for (i = 0; i < 17; i = i + 1) probe(edges[i]);
		for (i = 0; i < 64; i = i + 1)
		begin
			a = $random(seed);
			case (i % 8)
				0: a = a & 32'h1FFF;
				1: a = 32'h80000000 | (a & 32'hFFFFFF);
				2: a = 32'hFF000000 | (a & 32'h7FFFFF);
				3: a = 32'hFFE00000 | (a & 32'hFFFFF);
				4: a = 32'hFFFF1000 | (a & 32'hFF);
				5: a = 32'hFFFF2000 | (a & 32'hFF);
				6: a = 32'hFFFF3000 | (a & 32'hFF);
				default: a = a;
			endcase
			probe(a);
		end
		$display("decode test done");
		// boot jumper level, both ways
		repeat (3) @(posedge hclk);
		xfer(`BOOT_PORT_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h1);
		bj <= 1'b0;
		repeat (3) @(posedge hclk);
		xfer(`BOOT_PORT_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h0);
		// led: this master never overlaps phases, so the next read sees the new bit
		xfer(`LED_PORT_ADDR, 1'b1, 32'h1);
		xfer(`LED_PORT_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h1);
		xfer(`LED_PORT_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h1);
		chk(led_n, 1'b0);
		xfer(`LED_PORT_ADDR, 1'b1, 32'h0);
		repeat (2) @(posedge hclk);
		chk(led_n, 1'b1);
		$display("port test done");
		// wrong key is ignored, the right one reloads then resets devices
		xfer(`BOOT_PORT_ADDR, 1'b1, 32'h2);
		#1 chk(rel_n, 1'b1);
		xfer(`BOOT_PORT_ADDR, 1'b1, `SOFT_RESET_KEY);
		#1 chk(rel_n, 1'b0);
		// bus kept quiet for the whole sequence
		repeat (115) @(posedge hclk);
		chk({rel_n, dev_n}, 2'b11);
		// program jumper shorted through reset stalls configuration
		hresetn <= 1'b0;
		pj <= 1'b0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (3) @(posedge hclk);
		xfer(`BOOT_PORT_ADDR, 1'b0, 32'h0);
		chk(rd, 32'h2);
		xfer(`BOOT_PORT_ADDR, 1'b1, `SOFT_RESET_KEY);
		#1 chk(rel_n, 1'b1);
		repeat (115) @(posedge hclk);
		$display("reset test done");
		results;
	end
endmodule
